/* include/efp_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing for the fault logic
// Assumes: 200 MHz core clock, byte addressed word registers
// Notes: Times are given in microseconds; cycle counts derive from the clock rate
`ifndef EFP_REGS_SVH
`define EFP_REGS_SVH

`define EFP_ADDR_W 8
`define EFP_DATA_W 32
`define EFP_OFS_CTRL 8'h00
`define EFP_OFS_STATUS 8'h04
`define EFP_OFS_IRQ_STAT 8'h08
`define EFP_OFS_IRQ_MASK 8'h0C

// Control: [1:0] variant, [2] auto retry
`define EFP_CTRL_W 3
`define EFP_CTRL_VAR_LSB 0
`define EFP_CTRL_VAR_MSB 1
`define EFP_CTRL_AUTO 2
`define EFP_CTRL_VAR_BAD 2'h3
`define EFP_CTRL_RST 3'h0

// Interrupt events
`define EFP_IRQ_W 5
`define EFP_EV_LATCH 0
`define EFP_EV_FAULT 1
`define EFP_EV_OK_RISE 2
`define EFP_EV_OK_FALL 3
`define EFP_EV_RETRY 4
`define EFP_IRQ_RST 5'h00

// Status: [4:0] state, [5] fault_out_n, [6] power ok, [7] pass, [8] limit, [9] clamp
`define EFP_ST_FAULT 5
`define EFP_ST_OK 6
`define EFP_ST_PASS 7
`define EFP_ST_LIMIT 8
`define EFP_ST_CLAMP 9

// Clamp-select pin codes and clamp levels in millivolts
`define EFP_CSEL_GND 2'h0
`define EFP_CSEL_OPEN 2'h1
`define EFP_CSEL_RES 2'h2
`define EFP_CLAMP_MV_LOW 16'h0F32
`define EFP_CLAMP_MV_MID 16'h1680
`define EFP_CLAMP_MV_HIGH 16'h3638
`define EFP_CLAMP_MV_NONE 16'h0000

// Timing
`define EFP_CLK_MHZ 200
`define EFP_T_OK_ASSERT_US 10
`define EFP_T_OK_RELEASE_US 10
`define EFP_T_BLANK_US 20
`define EFP_T_RETRY_US 128
`define EFP_CYC(us) ((us) * `EFP_CLK_MHZ)

`endif

/* include/efp_pkg.sv */
// Purpose: Types shared by the fault and power-ok logic
// Assumes: Nothing beyond the register header
// Notes: State codes are one-hot
`default_nettype none
package efp_pkg;

  typedef enum logic [1:0] {
    EFP_VAR_FLAG = 2'h0,
    EFP_VAR_CLAMP = 2'h1,
    EFP_VAR_BREAKER = 2'h2
  } efp_variant_type;

  typedef enum logic [4:0] {
    EFP_OFF = 5'h01,
    EFP_INRUSH = 5'h02,
    EFP_ON = 5'h04,
    EFP_LATCHED = 5'h08,
    EFP_RETRY = 5'h10
  } efp_state_type;

  // Comparator outputs and the clamp-select strap code from the analog front end
  typedef struct packed {
    logic supply_present;
    logic supply_undervolt;
    logic enable_above_lockout;
    logic enable_above_shutdown;
    logic overtemp;
    logic overvolt;
    logic overcurrent;
    logic short_trip;
    logic monitor_short;
    logic gate_full;
    logic sense_above_rise;
    logic sense_above_fall;
    logic [1:0] clamp_level_select;
  } efp_sense_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } efp_bus_type;

endpackage : efp_pkg
`default_nettype wire

/* hdl/efp_filter.sv */
// Purpose: Level filter, output high once the input has stood high for CYCLES cycles
// Assumes: Synchronous input
// Notes: Dropping the input restarts the count at once
`default_nettype none
module efp_filter #(
  parameter int unsigned CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic level_in,
  output logic held_out
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("efp_filter needs CYCLES of at least one");
  end

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  wire at_max = (count == CW'(CYCLES));

  assign next_count = !level_in ? '0 : (at_max ? count : count + CW'(1));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count <= '0;
      held_out <= 1'b0;
    end else begin
      count <= next_count;
      held_out <= (next_count == CW'(CYCLES));
    end
  end
endmodule : efp_filter
`default_nettype wire

/* hdl/efp_core.sv */
// Purpose: Fault response, fault flag, power-ok and clamp select of a protective power switch
// Assumes: Comparator inputs synchronous to core_clk; variant set by software
// Notes: Registers over a plain strobe port; read data valid the cycle after the strobe
// Notes on behaviour
// - Only the fault-flag variant drives the active-low fault output; others hold it high.
// - A shorted current-monitor pin, held through the blanking interval, latches a shutdown.
// - An output short trips to current limit without latching and leaves the fault output high.
// - Undervoltage or lockout shuts down unlatched, fault output high, power-ok low.
// - Supply loss or enable below shutdown level clears the latch, fault flag and retry timer.
// - While latched, enable slightly under the lockout level is ignored.
// - Auto-retry restarts when the retry timer expires and then releases the fault output.
// - The clamp and breaker variants drive power-ok from the sense input and device state.
// - Power-ok stays low from power-up and through inrush.
// - Power-ok rises after the assert delay once gate is full and sense is above rising level.
// - Power-ok falls after the release delay on sense below falling level or a latched fault, breaker overcurrent included.
// - Flag and breaker variants have one mode and no clamp level.
// - The clamp variant picks 3.89 V, 5.76 V or 13.88 V from the clamp-select strap.
// - Auto-retry waits for cooling and then the retry delay before turning on if enabled.
// - Latch-off stays off after overtemperature until supply cycling or re-enable.
`include "efp_regs.svh"
`default_nettype none
module efp_core #(
  parameter int unsigned OK_ASSERT_CYCLES = `EFP_CYC(`EFP_T_OK_ASSERT_US),
  parameter int unsigned OK_RELEASE_CYCLES = `EFP_CYC(`EFP_T_OK_RELEASE_US),
  parameter int unsigned BLANK_CYCLES = `EFP_CYC(`EFP_T_BLANK_US),
  parameter int unsigned RETRY_CYCLES = `EFP_CYC(`EFP_T_RETRY_US)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire efp_pkg::efp_sense_type sense,
  input wire efp_pkg::efp_bus_type bus,
  output logic [31:0] rd_data,
  output logic fault_out_n,
  output logic power_ok_out,
  output logic pass_switch_on,
  output logic current_limit_on,
  output logic clamp_on,
  output logic [15:0] clamp_level_mv,
  output logic irq
);
  import efp_pkg::*;

  if (OK_ASSERT_CYCLES < 1 || OK_RELEASE_CYCLES < 1 || BLANK_CYCLES < 1
      || RETRY_CYCLES < 1) begin : g_bad_timing
    $error("efp_core timing counts must be at least one");
  end

  function automatic logic [15:0] clamp_decode(input logic [1:0] sel);
    unique case (sel)
      `EFP_CSEL_GND: clamp_decode = `EFP_CLAMP_MV_LOW;
      `EFP_CSEL_OPEN: clamp_decode = `EFP_CLAMP_MV_MID;
      `EFP_CSEL_RES: clamp_decode = `EFP_CLAMP_MV_HIGH;
      default: clamp_decode = `EFP_CLAMP_MV_NONE;
    endcase
  endfunction : clamp_decode

  logic [`EFP_CTRL_W-1:0] ctrl;
  logic [`EFP_IRQ_W-1:0] irq_stat;
  logic [`EFP_IRQ_W-1:0] irq_mask;
  efp_state_type state;
  efp_state_type next_state;

  // Variant and mode decode
  wire efp_variant_type variant = efp_variant_type'(ctrl[`EFP_CTRL_VAR_MSB:`EFP_CTRL_VAR_LSB]);
  wire is_flag = (variant == EFP_VAR_FLAG);
  wire is_clamp = (variant == EFP_VAR_CLAMP);
  wire is_breaker = (variant == EFP_VAR_BREAKER);
  wire has_ok = is_clamp | is_breaker;
  wire auto_retry = ctrl[`EFP_CTRL_AUTO];

  wire run = (state == EFP_INRUSH) | (state == EFP_ON);
  wire held_fault = (state == EFP_LATCHED) | (state == EFP_RETRY);
  wire power_lost = !sense.supply_present | sense.supply_undervolt
                    | !sense.enable_above_lockout;
  wire clear_latch = !sense.supply_present | !sense.enable_above_shutdown;
  wire ov_shutdown = sense.overvolt & !is_clamp;

  logic oc_blanked;
  logic mon_short_blanked;
  logic retry_done;
  logic ok_held;
  logic rel_held;

  efp_filter #(.CYCLES(BLANK_CYCLES)) u_oc_blank (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level_in(run & sense.overcurrent),
    .held_out(oc_blanked)
  );

  efp_filter #(.CYCLES(BLANK_CYCLES)) u_mon_blank (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level_in(run & sense.monitor_short),
    .held_out(mon_short_blanked)
  );

  // Timer runs only once cooled, and restarts whenever the retry state is left
  efp_filter #(.CYCLES(RETRY_CYCLES)) u_retry (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level_in((state == EFP_RETRY) & !sense.overtemp),
    .held_out(retry_done)
  );

  wire ok_cond = has_ok & (state == EFP_ON) & sense.gate_full & sense.sense_above_rise;
  wire rel_cond = (state != EFP_ON) | !sense.sense_above_fall;
  wire ok_force_low = !has_ok | (state == EFP_OFF) | (state == EFP_INRUSH);

  efp_filter #(.CYCLES(OK_ASSERT_CYCLES)) u_ok_assert (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level_in(ok_cond),
    .held_out(ok_held)
  );

  efp_filter #(.CYCLES(OK_RELEASE_CYCLES)) u_ok_release (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level_in(rel_cond),
    .held_out(rel_held)
  );

  wire latch_event = run & (sense.overtemp
                     | mon_short_blanked
                     | (oc_blanked & is_breaker));

  always_comb begin
    next_state = state;
    unique case (state)
      EFP_OFF: begin
        if (!power_lost && !ov_shutdown) begin
          next_state = EFP_INRUSH;
        end
      end
      EFP_INRUSH, EFP_ON: begin
        if (power_lost || ov_shutdown) begin
          next_state = EFP_OFF;
        end else if (latch_event) begin
          next_state = EFP_LATCHED;
        end else if (state == EFP_INRUSH && sense.gate_full) begin
          next_state = EFP_ON;
        end
      end
      EFP_LATCHED: begin
        // Lockout level alone does not clear; only the shutdown level does
        if (clear_latch) begin
          next_state = EFP_OFF;
        end else if (auto_retry && !sense.overtemp) begin
          next_state = EFP_RETRY;
        end
      end
      EFP_RETRY: begin
        if (clear_latch) begin
          next_state = EFP_OFF;
        end else if (retry_done) begin
          next_state = power_lost ? EFP_OFF : EFP_INRUSH;
        end
      end
    endcase
  end

  // Short trips current-limit but never pull the flag
  wire next_fault_n = !(is_flag & (held_fault
                      | (oc_blanked & !is_breaker & run)));
  wire next_limit = run & ((sense.overcurrent & !is_breaker) | sense.short_trip);
  wire next_clamp = is_clamp & run & sense.overvolt;
  wire [15:0] next_clamp_mv = is_clamp ? clamp_decode(sense.clamp_level_select)
                                       : `EFP_CLAMP_MV_NONE;

  wire next_ok = ok_force_low ? 1'b0
               : rel_held ? 1'b0
               : ok_held ? 1'b1
               : power_ok_out;

  wire [`EFP_IRQ_W-1:0] events;
  assign events[`EFP_EV_LATCH] = (state != EFP_LATCHED) & (next_state == EFP_LATCHED);
  assign events[`EFP_EV_FAULT] = fault_out_n & !next_fault_n;
  assign events[`EFP_EV_OK_RISE] = !power_ok_out & next_ok;
  assign events[`EFP_EV_OK_FALL] = power_ok_out & !next_ok;
  assign events[`EFP_EV_RETRY] = (state == EFP_RETRY) & (next_state == EFP_INRUSH);

  // Register port decode
  wire wr_ctrl = bus.wr & (bus.addr == `EFP_OFS_CTRL);
  wire wr_mask = bus.wr & (bus.addr == `EFP_OFS_IRQ_MASK);
  wire rd_stat = bus.rd & (bus.addr == `EFP_OFS_IRQ_STAT);
  wire var_ok = (bus.wdata[`EFP_CTRL_VAR_MSB:`EFP_CTRL_VAR_LSB] != `EFP_CTRL_VAR_BAD);
  wire [`EFP_CTRL_W-1:0] next_ctrl = (wr_ctrl && var_ok) ? bus.wdata[`EFP_CTRL_W-1:0] : ctrl;
  wire [`EFP_IRQ_W-1:0] next_mask = wr_mask ? bus.wdata[`EFP_IRQ_W-1:0] : irq_mask;
  // A new event in the clearing read's cycle survives
  wire [`EFP_IRQ_W-1:0] next_irq_stat = (rd_stat ? '0 : irq_stat) | events;

  wire [31:0] status_word = {22'h00_0000, next_clamp, current_limit_on, pass_switch_on,
                             power_ok_out, fault_out_n, state};
  wire [31:0] rd_mux =
      (bus.addr == `EFP_OFS_CTRL) ? {29'h0000_0000, ctrl} :
      (bus.addr == `EFP_OFS_STATUS) ? status_word :
      (bus.addr == `EFP_OFS_IRQ_STAT) ? {27'h000_0000, irq_stat} :
      (bus.addr == `EFP_OFS_IRQ_MASK) ? {27'h000_0000, irq_mask} : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= EFP_OFF;
      ctrl <= `EFP_CTRL_RST;
      irq_mask <= `EFP_IRQ_RST;
      irq_stat <= `EFP_IRQ_RST;
      irq <= 1'b0;
      rd_data <= 32'h0000_0000;
      fault_out_n <= 1'b1;
      power_ok_out <= 1'b0;
      pass_switch_on <= 1'b0;
      current_limit_on <= 1'b0;
      clamp_on <= 1'b0;
      clamp_level_mv <= `EFP_CLAMP_MV_NONE;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      irq_mask <= next_mask;
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & next_mask);
      rd_data <= bus.rd ? rd_mux : 32'h0000_0000;
      fault_out_n <= next_fault_n;
      power_ok_out <= next_ok;
      pass_switch_on <= (next_state == EFP_INRUSH) | (next_state == EFP_ON);
      current_limit_on <= next_limit;
      clamp_on <= next_clamp;
      clamp_level_mv <= next_clamp_mv;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_flag_variant_only: assert property (!is_flag |=> fault_out_n)
    else $error("fault output low on a variant without it");
  a_latch_pulls_flag: assert property (is_flag && state == EFP_LATCHED |=> !fault_out_n)
    else $error("latched fault did not pull the fault output");
  a_short_limits_only: assert property (
    run && sense.short_trip && !latch_event && !power_lost && !ov_shutdown
    |=> current_limit_on && state != EFP_LATCHED)
    else $error("output short did not current-limit or latched");
  a_lost_drops_ok: assert property (run && power_lost |=> state == EFP_OFF ##1 !power_ok_out)
    else $error("power-ok not low after undervoltage");
  a_clear_releases: assert property (
    state == EFP_LATCHED && clear_latch |=> state == EFP_OFF ##1 fault_out_n)
    else $error("latched fault not cleared");
  a_lockout_ignored: assert property (
    state == EFP_LATCHED && !clear_latch && (!auto_retry || sense.overtemp)
    |=> state == EFP_LATCHED)
    else $error("latched fault left without a clear");
  a_retry_restarts: assert property (
    state == EFP_RETRY && retry_done && !clear_latch && !power_lost
    |=> state == EFP_INRUSH ##1 fault_out_n)
    else $error("retry expiry did not restart");
  a_ok_low_inrush: assert property (
    state == EFP_OFF || state == EFP_INRUSH || !has_ok |=> !power_ok_out)
    else $error("power-ok high before inrush completes");
  a_ok_rise_cause: assert property ($rose(power_ok_out) |-> $past(ok_cond, 2))
    else $error("power-ok rose without gate full and sense above rise");
  a_ok_fall_cause: assert property (
    $fell(power_ok_out) |-> $past(rel_cond, 2) || $past(ok_force_low))
    else $error("power-ok fell without a cause");
  a_clamp_select: assert property (
    is_clamp && sense.clamp_level_select == `EFP_CSEL_GND |=> clamp_level_mv == `EFP_CLAMP_MV_LOW)
    else $error("clamp level not taken from strap");
  a_single_mode: assert property (!is_clamp |=> !clamp_on && clamp_level_mv == '0)
    else $error("clamp active on a single-mode variant");
  a_breaker_trips: assert property (
    run && is_breaker && oc_blanked && !power_lost && !ov_shutdown |=> state == EFP_LATCHED)
    else $error("breaker did not trip on persistent overcurrent");
  a_overtemp_latch: assert property (
    run && sense.overtemp && !power_lost && !ov_shutdown |=> state == EFP_LATCHED)
    else $error("overtemperature did not latch");
  a_limit_active: assert property (
    run && sense.overcurrent && !is_breaker |=> current_limit_on)
    else $error("overcurrent did not engage current limit");
  a_monitor_latch: assert property (
    run && mon_short_blanked && !power_lost && !ov_shutdown |=> state == EFP_LATCHED)
    else $error("shorted monitor pin did not latch");
  a_retry_waits: assert property (
    state == EFP_RETRY && !retry_done |=> state != EFP_INRUSH)
    else $error("restart before the retry delay ran out");
  a_retry_cleared: assert property (
    state == EFP_RETRY && clear_latch |=> state == EFP_OFF ##1 !retry_done)
    else $error("clear did not reset the retry timer");
  a_flag_in_retry: assert property (
    is_flag && state == EFP_RETRY |=> !fault_out_n)
    else $error("fault output released before the restart");
  a_ok_drop_latched: assert property (
    has_ok && state == EFP_LATCHED && rel_held |=> !power_ok_out)
    else $error("power-ok still high after a latched fault");
  a_clamp_active: assert property (
    is_clamp && run && sense.overvolt |=> clamp_on)
    else $error("clamp variant did not clamp overvoltage");
  a_off_no_pass: assert property (
    state == EFP_OFF |-> !pass_switch_on)
    else $error("pass switch on while shut down");
  a_fault_flag_oc: assert property (
    is_flag && run && oc_blanked |=> !fault_out_n)
    else $error("persistent overcurrent did not pull the fault output");
endmodule : efp_core
`default_nettype wire

/* tb/efp_load_model.sv */
// Purpose: Load-side partner that follows the power-ok and fault outputs
// Assumes: Outputs of the switch are registered levels
// Notes: The load runs only while power ok is high, as a downstream regulator would
`default_nettype none
module efp_load_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic power_ok_out,
  input wire logic fault_out_n,
  output logic load_on,
  output logic [7:0] fault_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      load_on <= 1'b0;
      fault_cycles <= 8'h00;
    end else begin
      load_on <= power_ok_out;
      if (!fault_out_n && fault_cycles != 8'hFF) begin
        fault_cycles <= fault_cycles + 8'h01;
      end
    end
  end
endmodule : efp_load_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the fault, power-ok and clamp-select logic
// Assumes: Short deglitch, blanking and retry counts of 3, 3, 4 and 8 cycles
// Notes: Inputs change by non-blocking assignment at the rising edge
`include "efp_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import efp_pkg::*;
  logic core_clk;
  logic sys_rst;
  efp_sense_type sns;
  efp_bus_type bus;
  logic [31:0] rd_data;
  logic fault_out_n;
  logic power_ok_out;
  logic pass_switch_on;
  logic current_limit_on;
  logic clamp_on;
  logic [15:0] clamp_level_mv;
  logic irq;
  logic load_on;
  logic [7:0] fault_cycles;
  int fails;
  int n_compared;

  efp_core #(.OK_ASSERT_CYCLES(3), .OK_RELEASE_CYCLES(3), .BLANK_CYCLES(4),
    .RETRY_CYCLES(8)) efp_core_i (.core_clk(core_clk), .sys_rst(sys_rst), .sense(sns),
    .bus(bus), .rd_data(rd_data), .fault_out_n(fault_out_n), .power_ok_out(power_ok_out),
    .pass_switch_on(pass_switch_on), .current_limit_on(current_limit_on),
    .clamp_on(clamp_on), .clamp_level_mv(clamp_level_mv), .irq(irq));

  efp_load_model efp_load_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .power_ok_out(power_ok_out), .fault_out_n(fault_out_n), .load_on(load_on),
    .fault_cycles(fault_cycles));

  always #2.5 core_clk = ~core_clk;

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    // Taken at the closing edge, before the design moves it on
    @(posedge core_clk);
    d = rd_data;
  endtask : rd

  // Polls the state field every three cycles; only for states that stand that long
  task automatic wait_st(input logic [4:0] st, input string nm);
    logic [31:0] d;
    d = 32'h0000_0000;
    for (int i = 0; i < 40 && d[4:0] !== st; i++) rd(`EFP_OFS_STATUS, d);
    chk(nm, {27'h000_0000, st}, {27'h000_0000, d[4:0]});
  endtask : wait_st

  task automatic wait_ok(input logic v);
    for (int i = 0; i < 20 && power_ok_out !== v; i++) @(posedge core_clk);
    chk("power_ok_out", v, power_ok_out);
  endtask : wait_ok

  task automatic power_up(input logic [31:0] ctl);
    wr(`EFP_OFS_CTRL, ctl);
    @(posedge core_clk);
    sns.supply_present <= 1'b1;
    sns.enable_above_lockout <= 1'b1;
    sns.enable_above_shutdown <= 1'b1;
    wait_st(5'h02, "inrush");
    chk("ok in inrush", 0, power_ok_out);
    sns.gate_full <= 1'b1;
    wait_st(5'h04, "on");
    chk("pass", 1, pass_switch_on);
  endtask : power_up

  task automatic power_down();
    @(posedge core_clk);
    sns <= '0;
    wait_st(5'h01, "off");
    chk("pass", 0, pass_switch_on);
  endtask : power_down

  task automatic t_reset();
    logic [31:0] d;
    chk("fault_out_n", 1, fault_out_n);
    chk("irq", 0, irq);
    chk("pass", 0, pass_switch_on);
    chk("fault_cycles", 0, fault_cycles);
    rd(`EFP_OFS_STATUS, d);
    chk("status", 32'h0000_0021, d);
    wr(`EFP_OFS_CTRL, 32'h0000_0003);
    rd(`EFP_OFS_CTRL, d);
    chk("ctrl", 32'h0000_0000, d);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, d);
    chk("unmapped", 32'h0000_0000, d);
    wr(`EFP_OFS_IRQ_MASK, 32'h0000_001F);
    rd(`EFP_OFS_IRQ_MASK, d);
    chk("mask", 32'h0000_001F, d);
    $display("test reset done");
  endtask : t_reset

  task automatic t_flag_otp();
    logic [31:0] d;
    wr(`EFP_OFS_IRQ_MASK, 32'h0000_0001);
    power_up(32'h0000_0000);
    chk("flag ok", 0, power_ok_out);
    sns.overtemp <= 1'b1;
    wait_st(5'h08, "latched");
    chk("pass", 0, pass_switch_on);
    repeat (2) @(posedge core_clk);
    chk("fault_out_n", 0, fault_out_n);
    chk("irq", 1, irq);
    rd(`EFP_OFS_IRQ_STAT, d);
    chk("irq stat", 32'h0000_0001, d & 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk("irq", 0, irq);
    sns.overtemp <= 1'b0;
    repeat (12) @(posedge core_clk);
    wait_st(5'h08, "latch off");
    sns.enable_above_lockout <= 1'b0;
    repeat (4) @(posedge core_clk);
    wait_st(5'h08, "near lockout");
    sns.enable_above_shutdown <= 1'b0;
    wait_st(5'h01, "cleared");
    repeat (2) @(posedge core_clk);
    chk("fault_out_n", 1, fault_out_n);
    power_down();
    $display("test flag overtemp done");
  endtask : t_flag_otp

  task automatic t_clamp_ok();
    logic [15:0] lv [3];
    lv = '{16'h0F32, 16'h1680, 16'h3638};
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      sns.clamp_level_select <= 2'(i);
      power_up(32'h0000_0001);
      chk("clamp level", lv[i], clamp_level_mv);
      sns.sense_above_rise <= 1'b1;
      sns.sense_above_fall <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("ok early", 0, power_ok_out);
      wait_ok(1'b1);
      @(posedge core_clk);
      chk("load_on", 1, load_on);
      sns.sense_above_rise <= 1'b0;
      sns.sense_above_fall <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("ok held", 1, power_ok_out);
      wait_ok(1'b0);
      sns.overvolt <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("clamp_on", 1, clamp_on);
      wait_st(5'h04, "clamping");
      sns.supply_undervolt <= 1'b1;
      wait_st(5'h01, "undervolt");
      chk("fault_out_n", 1, fault_out_n);
      chk("power_ok_out", 0, power_ok_out);
      power_down();
    end
    $display("test clamp power ok done");
  endtask : t_clamp_ok

  task automatic t_shorts();
    power_up(32'h0000_0000);
    sns.short_trip <= 1'b1;
    repeat (10) @(posedge core_clk);
    wait_st(5'h04, "short on");
    chk("fault_out_n", 1, fault_out_n);
    chk("limit", 1, current_limit_on);
    sns.short_trip <= 1'b0;
    sns.overcurrent <= 1'b1;
    for (int i = 0; i < 20 && fault_out_n !== 1'b0; i++) @(posedge core_clk);
    chk("fault_out_n", 0, fault_out_n);
    wait_st(5'h04, "limit on");
    @(posedge core_clk);
    sns.overcurrent <= 1'b0;
    sns.monitor_short <= 1'b1;
    repeat (2) @(posedge core_clk);
    wait_st(5'h08, "monitor short");
    repeat (2) @(posedge core_clk);
    chk("fault_out_n", 0, fault_out_n);
    power_down();
    $display("test shorts done");
  endtask : t_shorts

  task automatic t_retry();
    logic [31:0] d;
    power_up(32'h0000_0004);
    sns.overtemp <= 1'b1;
    wait_st(5'h08, "latched");
    repeat (12) @(posedge core_clk);
    wait_st(5'h08, "hot");
    sns.overtemp <= 1'b0;
    // Gate kept low so the restart stands in inrush long enough to be polled
    sns.gate_full <= 1'b0;
    wait_st(5'h10, "retry");
    chk("fault_out_n", 0, fault_out_n);
    wait_st(5'h02, "restart");
    repeat (2) @(posedge core_clk);
    chk("fault_out_n", 1, fault_out_n);
    rd(`EFP_OFS_IRQ_STAT, d);
    chk("retry event", 32'h0000_0010, d & 32'h0000_0010);
    power_down();
    $display("test retry done");
  endtask : t_retry

  task automatic t_breaker();
    power_up(32'h0000_0002);
    chk("clamp level", 0, clamp_level_mv);
    sns.sense_above_rise <= 1'b1;
    sns.sense_above_fall <= 1'b1;
    wait_ok(1'b1);
    sns.overcurrent <= 1'b1;
    wait_st(5'h08, "breaker");
    wait_ok(1'b0);
    chk("fault_out_n", 1, fault_out_n);
    power_down();
    $display("test breaker done");
  endtask : t_breaker

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    sns = '0;
    bus = '0;
    fails = 0;
    n_compared = 0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_flag_otp();
    t_clamp_ok();
    t_shorts();
    t_retry();
    t_breaker();
    finish_test();
  end

  // The tests need about 300 cycles; fifty times that means a hang
  initial begin
    #75000;
    fails++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
